/* design/rwsp_defs.svh */
// constants for the self-programming control block
// Contract
// R1 - store-program from application section ignored
// R2 - programming starts only from loader section
// R3 - loader may target any flash page
// R4 - section boundary from loader size fuses
// R5 - application lock bits restrict application section
// R6 - loader lock bits restrict loader section
// R7 - fixed concurrent/halting boundary, fuse independent
// R8 - concurrent-region program keeps cpu running
// R9 - halting-region program stalls cpu throughout
// R10 - no concurrent-region code during programming
// R11 - loader section always inside halting region
// R12 - busy flag reads one while blocked
// R13 - region blocked until software clears busy
// R14 - firmware disables interrupts during concurrent programming
// R15 - programming in pages, fetch unaffected
// R16 - application lock encoding 11/10/00/01
// R17 - loader lock same encoding, application reads
// R18 - busy set on start, cleared by enable/load
// R19 - lock bits cleared only by chip erase; code also reloads them to 1111 on reset
// R20 - stalled cpu resumes after store instruction
`ifndef RWSP_DEFS_SVH
`define RWSP_DEFS_SVH
`define RWSP_ADDR_W 16
`define RWSP_PAGE_W 7
`define RWSP_FLASH_WORDS 32'h0001_0000
`define RWSP_HALT_WORDS 32'h0000_1000
`define RWSP_LOADER_UNIT 32'h0000_0200
`define RWSP_OP_CYCLES 32'd1000
`define RWSP_REG_CTRL 4'h0
`define RWSP_REG_LOCK 4'h1
`define RWSP_CTRL_BUSY 6
`define RWSP_CTRL_RDEN 4
`define RWSP_CTRL_LOAD 3
`define RWSP_CTRL_PWRT 2
`define RWSP_CTRL_PERS 1
`define RWSP_CTRL_SPMEN 0
`define RWSP_LOCK_RESET 4'hF
`endif

/* design/rwsp_pkg.sv */
// types for the self-programming control block
package rwsp_pkg;
  typedef enum logic [1:0] {
    RWSP_IDLE = 2'b00,
    RWSP_RUN = 2'b01,
    RWSP_DONE = 2'b10
  } rwsp_state_t;
endpackage

/* design/rwsp_self_prog.sv */
// self-programming control: section gating, locks, stall and busy flag
`timescale 1ns/1ps
`include "rwsp_defs.svh"
module rwsp_self_prog import rwsp_pkg::*; #(
  parameter int ADDR_W = `RWSP_ADDR_W,
  parameter int OP_CYCLES = `RWSP_OP_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [1:0] loaderSizeFuses,
  input wire logic [ADDR_W-1:0] fetchAddr,
  input wire logic storeProgramInstr,
  input wire logic [ADDR_W-1:0] targetAddr,
  input wire logic pmRead,
  input wire logic [ADDR_W-1:0] pmReadAddr,
  input wire logic chipErase,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  output logic cpuStall,
  output logic flashStart,
  output logic flashErase,
  output logic [ADDR_W-1:0] flashAddr,
  output logic pageLoadStrobe,
  output logic fetchBlocked,
  output logic readBlocked,
  output logic concurrentRegionBusy
);
  // flash is fixed at 64K words and the halting region at 4K words, so only a 16-bit address can serve them
  if (ADDR_W != 16 || OP_CYCLES < 1) begin : g_bad_params
    $error("rwsp: bad parameters");
  end
  logic rstMeta, rstSync;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end
  logic [1:0] fuseMeta, fuseQ;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fuseMeta <= 2'b11;
      fuseQ <= 2'b11;
    end else begin
      fuseMeta <= loaderSizeFuses;
      fuseQ <= fuseMeta;
    end
  end
  // loader start: 11 smallest loader, 00 largest; always within halting region
  function automatic logic [ADDR_W:0] loaderStart(input logic [1:0] f);
    logic [31:0] sz;
    sz = `RWSP_LOADER_UNIT << (2'd3 - f);
    loaderStart = (ADDR_W+1)'(`RWSP_FLASH_WORDS - sz); // R4 R11
  endfunction
  function automatic logic inHalt(input logic [ADDR_W-1:0] a);
    inHalt = {1'b0, a} >= (ADDR_W+1)'(`RWSP_FLASH_WORDS - `RWSP_HALT_WORDS); // R7
  endfunction
  wire [ADDR_W:0] bootBase = loaderStart(fuseQ);
  wire fetchInLoader = {1'b0, fetchAddr} >= bootBase;
  wire targetInLoader = {1'b0, targetAddr} >= bootBase;
  wire readInLoader = {1'b0, pmReadAddr} >= bootBase;
  logic [3:0] lock_q, lock_d;
  logic [7:0] ctrl_q;
  logic busy_q, busy_d;
  rwsp_state_t state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic opHalt_q;
  // lock bit 0 programmed = write block, bit 1 programmed = read block (hi/lo per 11/10/00/01)
  wire appWrBlock = lock_q[1:0] == 2'b10 || lock_q[1:0] == 2'b00; // R5 R16
  wire appRdBlock = lock_q[1:0] == 2'b00 || lock_q[1:0] == 2'b01; // R5 R16
  wire ldrWrBlock = lock_q[3:2] == 2'b10 || lock_q[3:2] == 2'b00; // R6 R17
  wire ldrRdBlock = lock_q[3:2] == 2'b00 || lock_q[3:2] == 2'b01; // R6 R17
  wire spmArmed = ctrl_q[`RWSP_CTRL_SPMEN];
  wire opReq = ctrl_q[`RWSP_CTRL_PERS] | ctrl_q[`RWSP_CTRL_PWRT];
  wire wrAllowed = targetInLoader ? !ldrWrBlock : !appWrBlock; // R3
  // store from application is dropped outright; no side effects at all
  wire doStore = storeProgramInstr && fetchInLoader && spmArmed && state_q == RWSP_IDLE; // R1 R2
  wire startOp = doStore && opReq && wrAllowed;
  wire startLoad = doStore && ctrl_q[`RWSP_CTRL_LOAD];
  wire ctrlWr = regWr && regAddr == `RWSP_REG_CTRL;
  wire lockWr = regWr && regAddr == `RWSP_REG_LOCK;
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    case (state_q)
      RWSP_IDLE: begin
        if (startOp) begin
          state_d = RWSP_RUN;
          cnt_d = 32'(OP_CYCLES - 1);
          if (!inHalt(targetAddr)) busy_d = 1'b1; // R18
        end
      end
      RWSP_RUN: begin
        if (cnt_q == 32'd0) state_d = RWSP_DONE;
        else cnt_d = cnt_q - 32'd1;
      end
      RWSP_DONE: state_d = RWSP_IDLE;
      default: state_d = RWSP_IDLE;
    endcase
    // busy stays until software re-enables reads after completion or a page load starts
    if (state_q == RWSP_IDLE && !startOp && busy_q) begin
      if ((ctrlWr && regWdata[`RWSP_CTRL_RDEN] && regWdata[`RWSP_CTRL_SPMEN]) || startLoad)
        busy_d = 1'b0; // R13 R18
    end
  end
  always_comb begin
    lock_d = lock_q;
    if (chipErase) lock_d = `RWSP_LOCK_RESET; // R19
    else if (lockWr && spmArmed) lock_d = lock_q & regWdata[3:0]; // R19
  end
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      state_q <= RWSP_IDLE;
      cnt_q <= 32'd0;
      busy_q <= 1'b0;
      opHalt_q <= 1'b0;
      ctrl_q <= 8'h00;
      lock_q <= `RWSP_LOCK_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      lock_q <= lock_d;
      if (startOp) opHalt_q <= inHalt(targetAddr);
      if (ctrlWr) ctrl_q <= {3'b000, regWdata[4:0]};
      else if (doStore || state_q == RWSP_DONE) ctrl_q <= 8'h00;
    end
  end
  // stall only while a halting-region page is busy; pc held so cpu resumes after the store
  assign cpuStall = state_q == RWSP_RUN && opHalt_q; // R8 R9 R20
  assign fetchBlocked = busy_q && !inHalt(fetchAddr); // R10 R13
  wire rdCross = readInLoader ? (!fetchInLoader && ldrRdBlock) : (fetchInLoader && appRdBlock);
  assign readBlocked = pmRead && ((busy_q && !inHalt(pmReadAddr)) || rdCross); // R10 R16 R17
  assign concurrentRegionBusy = busy_q; // R12
  // page grouping only affects programming address, not reads
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      flashStart <= 1'b0;
      flashErase <= 1'b0;
      flashAddr <= '0;
      pageLoadStrobe <= 1'b0;
      regRdata <= 8'h00;
    end else begin
      flashStart <= startOp;
      pageLoadStrobe <= startLoad;
      if (startOp) begin
        flashErase <= ctrl_q[`RWSP_CTRL_PERS];
        flashAddr <= {targetAddr[ADDR_W-1:`RWSP_PAGE_W], `RWSP_PAGE_W'(0)}; // R15
      end
      if (regRd && regAddr == `RWSP_REG_CTRL)
        regRdata <= {1'b0, busy_q, 1'b0, ctrl_q[4:1], spmArmed | state_q != RWSP_IDLE}; // R12
      else if (regRd && regAddr == `RWSP_REG_LOCK) regRdata <= {4'h0, lock_q};
      else regRdata <= 8'h00;
    end
  end
endmodule

/* verif/rwsp_cpu_model.sv */
// cpu core model running loader firmware
`timescale 1ns/1ps
module rwsp_cpu_model (
  input wire logic core_clk,
  input wire logic cpuStall,
  output logic [15:0] fetchAddr = 16'h0000,
  output logic storeProgramInstr = 1'b0,
  output logic [15:0] targetAddr = 16'h0000
);
  // interrupts stay off while programming, so no vector fetch
  task automatic store(input logic [15:0] pc, tgt);
    fetchAddr <= pc;
    targetAddr <= tgt;
    storeProgramInstr <= 1'b1;
    @(posedge core_clk);
    storeProgramInstr <= 1'b0;
    targetAddr <= ~tgt;
    @(posedge core_clk);
    while (cpuStall) begin
      @(posedge core_clk);
    end
    fetchAddr <= pc + 16'h0001;
  endtask
endmodule

/* verif/rwsp_self_prog_sva.sv */
// assertions for the self-programming control block
`timescale 1ns/1ps
module rwsp_self_prog_sva #(
  parameter int ADDR_W = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] fetchAddr,
  input wire logic storeProgramInstr,
  input wire logic regWr,
  input wire logic pmRead,
  input wire logic [ADDR_W-1:0] pmReadAddr,
  input wire logic cpuStall,
  input wire logic flashStart,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic fetchBlocked,
  input wire logic readBlocked,
  input wire logic concurrentRegionBusy
);
  // halting region base; every loader size starts at or above it
  localparam logic [ADDR_W-1:0] HALT = 16'hF000;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_app_ignored: assert property (storeProgramInstr && fetchAddr < HALT |=> !flashStart)
    else $error("app store started");
  a_start_cause: assert property (flashStart |->
    $past(storeProgramInstr) && $past(fetchAddr) >= HALT) else $error("stray start");
  a_busy_start: assert property (flashStart && flashAddr < HALT |->
    concurrentRegionBusy && !cpuStall) else $error("busy or stall wrong");
  a_halt_stall: assert property (flashStart && flashAddr >= HALT |-> cpuStall [*8])
    else $error("stall too short");
  a_read_blocked: assert property (concurrentRegionBusy && pmRead && pmReadAddr < HALT
    |-> readBlocked) else $error("read not blocked");
  a_fetch_blocked: assert property (concurrentRegionBusy && fetchAddr < HALT |-> fetchBlocked)
    else $error("fetch not blocked");
  a_busy_holds: assert property (concurrentRegionBusy && !regWr && !storeProgramInstr
    |=> concurrentRegionBusy) else $error("busy dropped");
  a_halt_fetch: assert property (fetchAddr >= HALT |-> !fetchBlocked)
    else $error("halting fetch blocked");
  cover property (flashStart && cpuStall);
  cover property (flashStart && concurrentRegionBusy);
  cover property (readBlocked);
endmodule
bind rwsp_self_prog rwsp_self_prog_sva #(.ADDR_W(ADDR_W)) i_rwsp_self_prog_sva (.*);

/* verif/rwsp_self_prog_tb_top.sv */
// self-checking bench for the self-programming control block
`timescale 1ns/1ps
module rwsp_self_prog_tb_top;
  localparam int OPC = 8;
  logic core_clk = 1'b0, rstn = 1'b0, pmRead = 1'b0, chipErase = 1'b0, regWr = 1'b0;
  logic regRd = 1'b0, rdQ = 1'b0;
  logic [1:0] loaderSizeFuses = 2'b11;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic [15:0] pmReadAddr = 16'h0000, fetchAddr, targetAddr, flashAddr, t;
  logic storeProgramInstr, cpuStall, flashStart, flashErase, pageLoadStrobe;
  logic fetchBlocked, readBlocked, concurrentRegionBusy;
  logic [15:0] expQ[$];
  int n_mismatch = 0, num_checks = 0, cyc = 0, stallRun = 0;
  initial forever #12.5 core_clk = ~core_clk;
  rwsp_cpu_model i_rwsp_cpu_model (.*);
  rwsp_self_prog #(.OP_CYCLES(OPC)) i_rwsp_self_prog (.*);
  task automatic check(input string what, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    expQ.push_back(16'(e));
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(posedge core_clk);
  endtask
  function automatic logic [15:0] nextExp();
    nextExp = expQ.size() ? expQ.pop_front() : 16'hXXXX;
  endfunction
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 2000) begin
      n_mismatch++;
      complete_run();
    end
    if (flashStart) check("flashAddr", flashAddr, nextExp());
    if (flashStart) check("flashErase", 16'(flashErase), nextExp());
    if (pageLoadStrobe) check("loadBusy", 16'(concurrentRegionBusy), nextExp());
    if (rdQ) check("regRdata", 16'(regRdata), nextExp());
    rdQ <= regRd;
    if (cpuStall)
      stallRun++;
    else if (stallRun > 0) begin
      check("stall", 16'(stallRun), 16'(OPC));
      stallRun = 0;
    end
  end
  initial begin
    t = 16'($urandom(32'hAAB5AE81));
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    wr(4'h0, 8'h03);
    i_rwsp_cpu_model.store(16'h0100, 16'h0200);
    wr(4'h0, 8'h03);
    i_rwsp_cpu_model.store(16'hF000, 16'hF800);
    $display("test refusals done");
    t = 16'($urandom % 32'hF000) & 16'hFF80;
    wr(4'h0, 8'h03);
    expQ.push_back(t);
    expQ.push_back(16'h0001);
    i_rwsp_cpu_model.store(16'hFE00, t);
    pmRead <= 1'b1;
    pmReadAddr <= t;
    wr(4'h0, 8'h11);
    check("readBlocked", 16'(readBlocked), 16'h0001);
    rd(4'h0, 8'h51);
    pmRead <= 1'b0;
    repeat (OPC + 2) @(posedge core_clk);
    rd(4'h0, 8'h40);
    wr(4'h0, 8'h11);
    rd(4'h0, 8'h11);
    rd(4'h5, 8'h00);
    $display("test concurrent done");
    loaderSizeFuses <= 2'b00;
    repeat (3) @(posedge core_clk);
    wr(4'h0, 8'h03);
    expQ.push_back(16'hF800);
    expQ.push_back(16'h0001);
    i_rwsp_cpu_model.store(16'hF000, 16'hF800);
    @(posedge core_clk);
    check("fetchAddr", fetchAddr, 16'hF001);
    $display("test halting done");
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h02);
    rd(4'h1, 8'h02);
    wr(4'h0, 8'h03);
    i_rwsp_cpu_model.store(16'hF000, 16'h0100);
    wr(4'h0, 8'h03);
    i_rwsp_cpu_model.store(16'hF000, 16'hF800);
    chipErase <= 1'b1;
    @(posedge core_clk);
    chipErase <= 1'b0;
    rd(4'h1, 8'h0F);
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h0D);
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h0F);
    rd(4'h1, 8'h0D);
    pmRead <= 1'b1;
    pmReadAddr <= 16'h0100;
    @(posedge core_clk);
    check("readBlocked", 16'(readBlocked), 16'h0001);
    pmRead <= 1'b0;
    wr(4'h0, 8'h05);
    expQ.push_back(16'h0100);
    expQ.push_back(16'h0000);
    i_rwsp_cpu_model.store(16'hF000, 16'h0100);
    $display("test locks done");
    repeat (OPC + 4) @(posedge core_clk);
    i_rwsp_cpu_model.store(16'h0100, 16'h0180);
    check("fetchBlocked", 16'(fetchBlocked), 16'h0001);
    expQ.push_back(16'h0000);
    wr(4'h0, 8'h09);
    i_rwsp_cpu_model.store(16'hF000, 16'h0180);
    rd(4'h0, 8'h00);
    $display("test page load done");
    repeat (4) @(posedge core_clk);
    check("pending", 16'(expQ.size()), 16'h0000);
    complete_run();
  end
endmodule
